// File: inc/rtoi_pkg.sv
// Constants and carrier types of the rail telemetry and on/off block
package rtoi_pkg;
	// Fixed upper address bits of the two slave functions
	localparam logic [4:0] TEL_ADDR_HI     = 5'h12;
	localparam logic [4:0] CTL_ADDR_HI     = 5'h1D;
	// Output switch register offset, also the first unlock command
	localparam logic [7:0] OUTPUT_SWITCH_MASK_OFS = 8'h02;
	localparam logic [7:0] CMD_UNLOCK2     = 8'h06;
	localparam logic [7:0] UNLOCK_DATA     = 8'h00;
	// Telemetry command layout
	localparam int         TEL_FLAG_BIT    = 7;
	localparam int         TEL_SRC_MSB     = 6;
	localparam int         TEL_SRC_LSB     = 4;
	localparam logic [3:0] TEL_LOW_ZERO    = 4'h0;
	localparam logic [2:0] SRC_TEMP        = 3'h0;
	localparam logic [2:0] SRC_MAIN        = 3'h4;
	localparam logic [2:0] SRC_LOW         = 3'h1;
	localparam logic [2:0] SRC_MID         = 3'h5;
	localparam logic [2:0] SRC_PAUX        = 3'h2;
	localparam logic [2:0] SRC_NAUX        = 3'h6;
	localparam logic [7:0] REPLY_BAD       = 8'h00;
	localparam logic [7:0] REPLY_IDLE      = 8'hFF;
	// Output switch mask field positions
	localparam int         SW_MAIN_BIT     = 0;
	localparam int         SW_LOW_BIT      = 1;
	localparam int         SW_GROUP_BIT    = 2;
	localparam int         SW_MID_BIT      = 3;
	localparam int         SW_PAUX_BIT     = 4;
	localparam int         SW_NAUX_BIT     = 5;
	localparam int         SW_USED_W       = 6;
	localparam logic [5:0] MASK_RESET      = 6'h00;
	// Timing figures
	localparam int         SCL_MAX_KHZ     = 200;
	localparam int         CLK_MHZ         = 40;
	localparam int         LINK_PERIOD_NS  = 64;
	localparam int         MIN_OVERSAMPLE  = 8;
	localparam int         SCL_MIN_PER_NS  = 1000000 / SCL_MAX_KHZ;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

	typedef struct packed {
		logic [7:0] temp;
		logic [7:0] main_rail;
		logic [7:0] low_rail;
		logic [7:0] mid_rail;
		logic [7:0] positive_aux_rail;
		logic [7:0] negative_aux_rail;
	} rtoi_readings_t;

	typedef struct packed {
		logic main_rail;
		logic low_rail;
		logic mid_rail;
		logic positive_aux_rail;
		logic negative_aux_rail;
		logic aux_low_rail;
	} rtoi_rails_t;

	typedef enum logic [2:0] {
		L_IDLE = 3'h0,
		L_ADDR = 3'h1,
		L_AACK = 3'h3,
		L_WR   = 3'h2,
		L_WACK = 3'h6,
		L_RD   = 3'h7,
		L_RACK = 3'h5
	} rtoi_link_st_t;

	typedef enum logic [1:0] {
		LK_NONE  = 2'h0,
		LK_FIRST = 2'h1,
		LK_OPEN  = 2'h3
	} rtoi_lock_st_t;
endpackage : rtoi_pkg

// File: src/rtoi_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module rtoi_sync #(
	parameter int W = 1
) (
	input  wire logic         clk, // Destination clock
	input  wire logic         rst, // Synchronous reset, active high
	input  wire logic [W-1:0] d,   // Asynchronous level
	output logic      [W-1:0] q    // Synchronised level
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;

	if (W < 1) begin : g_bad_w
		$error("rtoi_sync: W must be at least one");
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
		end
	end

	assign q = s2_reg;
endmodule : rtoi_sync

// File: src/rtoi_top.sv
// Management logic: telemetry and output on/off serial slaves, control pins
//
// Behaviour
// RULE1: Telemetry slave answers address 10010 plus the two slot bits.
// RULE2: slot_addr_hi is address bit 1, slot_addr_lo address bit 0.
// RULE3: On/off controller answers address 11101 plus the two slot bits.
// RULE4: Master keeps the serial clock at or below 200 kHz.
// RULE5: Telemetry command: bit7 set, bits 6..4 pick source, bits 3..0 zero.
// RULE6: Each telemetry reply is exactly one byte.
// RULE7: Reply byte is the linear scaled reading of the chosen source.
// RULE8: After power-up every output is switched on.
// RULE9: Master unlocks with writes 0x02/0x00 then 0x06/0x00.
// RULE10: Master changes outputs by writing command 0x02 plus a data byte.
// RULE11: Bit 0 set turns the main 12V output off.
// RULE12: Bit 1 set turns the 3.3V output off.
// RULE13: Bit 2 set turns 5V and both auxiliary 12V outputs off.
// RULE14: Bit 3 set turns the 5V output off.
// RULE15: Bit 4 set turns the positive auxiliary output off.
// RULE16: Bit 5 set turns the negative auxiliary output off.
// RULE17: Bits 6 and 7 of the control byte are ignored.
// RULE18: Enable high: all off; hold-off high: all on; else aux 3.3V only.
// RULE19: Fault output shows a failure on any output.
// RULE20: Outputs-good shows every output within its working level.
// RULE21: Control writes are ignored until unlocked; unlock then stays.
// RULE22: Telemetry read is a command write then a one-byte read.
`timescale 1ns/1ps
module rtoi_top #(
	parameter int LINK_NS = rtoi_pkg::LINK_PERIOD_NS
) (
	input  wire logic                    clk,            // System clock
	input  wire logic                    sys_rst,        // Reset, active high
	input  wire logic                    link_clk,       // Serial sampling clock
	input  wire logic                    scl_i,          // Serial clock pin
	input  wire logic                    sda_i,          // Serial data pin in
	output logic                         sda_o,          // Serial data out
	output logic                         sda_oe,         // Drive data low
	input  wire logic                    slot_addr_hi,   // Slot address bit 1
	input  wire logic                    slot_addr_lo,   // Slot address bit 0
	input  wire logic                    enable_n,       // Enable control pin
	input  wire logic                    holdoff_n,      // Hold-off pin
	input  wire rtoi_pkg::rtoi_readings_t readings_i,    // Scaled readings
	input  wire rtoi_pkg::rtoi_rails_t   rail_fault_i,   // Per-output fault
	input  wire rtoi_pkg::rtoi_rails_t   rail_good_i,    // Per-output in range
	output rtoi_pkg::rtoi_rails_t        rail_on,        // Output switch-on
	output logic                         fault_n,        // Failure, low
	output logic                         outputs_good_n  // All good, low
);
	if ((rtoi_pkg::SCL_MIN_PER_NS / LINK_NS) < rtoi_pkg::MIN_OVERSAMPLE)
	begin : g_bad_link
		$error("rtoi_top: link clock too slow to sample the serial bus");
	end

	// Link domain
	logic                    lrst;
	logic                    scl_s;
	logic                    sda_s;
	logic [1:0]              slot_s;
	logic                    ack_s;
	rtoi_pkg::rtoi_link_st_t st_reg, st_next;
	logic [3:0]              cnt_reg, cnt_next;
	logic [7:0]              sr_reg, sr_next;
	logic                    oe_reg, oe_next;
	logic                    tel_reg, tel_next;
	logic                    rw_reg, rw_next;
	logic [1:0]              bidx_reg, bidx_next;
	logic [7:0]              cmd_reg, cmd_next;
	logic [7:0]              data_reg, data_next;
	logic                    ttg_reg, ttg_next;
	logic                    wtg_reg, wtg_next;
	logic                    scl_d_reg;
	logic                    sda_d_reg;
	logic                    sda_o_reg;
	logic                    start, stop, scl_rise, scl_fall;
	logic [6:0]              tel_addr, ctl_addr;
	// System domain
	logic                    en_s, hold_s, tt_s, wt_s;
	rtoi_pkg::rtoi_rails_t   fault_s, good_s;
	logic                    tt_seen_reg, wt_seen_reg;
	logic                    tel_evt, wr_evt;
	rtoi_pkg::rtoi_lock_st_t lk_reg, lk_next;
	logic [5:0]              mask_reg, mask_next;
	logic [7:0]              reply_reg, reply_next;
	logic                    ack_reg, ack_next;
	rtoi_pkg::rtoi_rails_t   on_reg, on_next;
	logic                    fault_n_reg, fault_n_next;
	logic                    good_n_reg, good_n_next;
	logic                    all_on;
	logic [2:0]              src;

	rtoi_sync #(.W(1)) u_rst_sync (
		.clk (link_clk),
		.rst (1'b0),
		.d   (sys_rst),
		.q   (lrst)
	);

	rtoi_sync #(.W(5)) u_link_sync (
		.clk (link_clk),
		.rst (lrst),
		.d   ({scl_i, sda_i, slot_addr_hi, slot_addr_lo, ack_reg}),
		.q   ({scl_s, sda_s, slot_s, ack_s})
	);

	rtoi_sync #(.W(16)) u_sys_sync (
		.clk (clk),
		.rst (sys_rst),
		.d   ({enable_n, holdoff_n, rail_fault_i, rail_good_i,
		       ttg_reg, wtg_reg}),
		.q   ({en_s, hold_s, fault_s, good_s, tt_s, wt_s})
	);

	assign start    = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
	assign stop     = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
	assign scl_rise = scl_s & ~scl_d_reg;
	assign scl_fall = ~scl_s & scl_d_reg;
	assign tel_addr = {rtoi_pkg::TEL_ADDR_HI, slot_s}; // RULE1 RULE2
	assign ctl_addr = {rtoi_pkg::CTL_ADDR_HI, slot_s}; // RULE3 RULE2

	always_comb begin
		st_next   = st_reg;
		cnt_next  = cnt_reg;
		sr_next   = sr_reg;
		oe_next   = oe_reg;
		tel_next  = tel_reg;
		rw_next   = rw_reg;
		bidx_next = bidx_reg;
		cmd_next  = cmd_reg;
		data_next = data_reg;
		ttg_next  = ttg_reg;
		wtg_next  = wtg_reg;
		if (start) begin
			st_next   = rtoi_pkg::L_ADDR;
			cnt_next  = 4'h0;
			oe_next   = 1'b0;
			bidx_next = 2'h0;
		end else if (stop) begin
			st_next = rtoi_pkg::L_IDLE;
			oe_next = 1'b0;
		end else if (scl_rise) begin
			if (st_reg == rtoi_pkg::L_ADDR ||
			    st_reg == rtoi_pkg::L_WR) begin
				sr_next  = {sr_reg[6:0], sda_s};
				cnt_next = cnt_reg + 4'h1;
			end
		end else if (scl_fall) begin
			unique case (st_reg)
			rtoi_pkg::L_IDLE: begin
			end
			rtoi_pkg::L_ADDR: begin
				if (cnt_reg == rtoi_pkg::BITS_PER_BYTE) begin
					// Controller is write-only, so a read to it is refused
					if (sr_reg[7:1] == tel_addr) begin // RULE1
						st_next = rtoi_pkg::L_AACK;
						oe_next = 1'b1;
					end else if (sr_reg[7:1] == ctl_addr &&
					             !sr_reg[0]) begin // RULE3
						st_next = rtoi_pkg::L_AACK;
						oe_next = 1'b1;
					end else begin
						st_next = rtoi_pkg::L_IDLE;
					end
					tel_next = (sr_reg[7:1] == tel_addr);
					rw_next  = sr_reg[0];
				end
			end
			rtoi_pkg::L_AACK: begin
				cnt_next = 4'h0;
				if (rw_reg) begin // RULE22
					st_next = rtoi_pkg::L_RD;
					sr_next = (ack_s == ttg_reg) ? reply_reg
					          : rtoi_pkg::REPLY_IDLE;
					oe_next = ~sr_next[7];
				end else begin
					st_next = rtoi_pkg::L_WR;
					oe_next = 1'b0;
				end
			end
			rtoi_pkg::L_WR: begin
				if (cnt_reg == rtoi_pkg::BITS_PER_BYTE) begin
					st_next = rtoi_pkg::L_WACK;
					oe_next = 1'b1;
					if (bidx_reg == 2'h0) begin
						cmd_next = sr_reg;
						if (tel_reg) begin
							ttg_next = ~ttg_reg; // RULE22
						end
					end
					if (bidx_reg == 2'h1) begin
						data_next = sr_reg;
						if (!tel_reg) begin
							wtg_next = ~wtg_reg; // RULE10
						end
					end
					if (bidx_reg != 2'h3) begin
						bidx_next = bidx_reg + 2'h1;
					end
				end
			end
			rtoi_pkg::L_WACK: begin
				st_next  = rtoi_pkg::L_WR;
				oe_next  = 1'b0;
				cnt_next = 4'h0;
			end
			rtoi_pkg::L_RD: begin
				if (cnt_reg == 4'h7) begin
					st_next = rtoi_pkg::L_RACK;
					oe_next = 1'b0;
				end else begin
					sr_next  = {sr_reg[6:0], 1'b1};
					oe_next  = ~sr_reg[6];
					cnt_next = cnt_reg + 4'h1;
				end
			end
			rtoi_pkg::L_RACK: begin
				st_next = rtoi_pkg::L_IDLE; // RULE6
				oe_next = 1'b0;
			end
			default: begin
				st_next = rtoi_pkg::L_IDLE;
				oe_next = 1'b0;
			end
			endcase
		end
	end

	always_ff @(posedge link_clk) begin
		if (lrst) begin
			st_reg    <= rtoi_pkg::L_IDLE;
			cnt_reg   <= 4'h0;
			sr_reg    <= 8'h00;
			oe_reg    <= 1'b0;
			tel_reg   <= 1'b0;
			rw_reg    <= 1'b0;
			bidx_reg  <= 2'h0;
			cmd_reg   <= 8'h00;
			data_reg  <= 8'h00;
			ttg_reg   <= 1'b0;
			wtg_reg   <= 1'b0;
			scl_d_reg <= 1'b1;
			sda_d_reg <= 1'b1;
			sda_o_reg <= 1'b0;
		end else begin
			st_reg    <= st_next;
			cnt_reg   <= cnt_next;
			sr_reg    <= sr_next;
			oe_reg    <= oe_next;
			tel_reg   <= tel_next;
			rw_reg    <= rw_next;
			bidx_reg  <= bidx_next;
			cmd_reg   <= cmd_next;
			data_reg  <= data_next;
			ttg_reg   <= ttg_next;
			wtg_reg   <= wtg_next;
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			sda_o_reg <= 1'b0;
		end
	end

	assign sda_o  = sda_o_reg;
	assign sda_oe = oe_reg;

	// System domain: telemetry command and control data bytes are written in the same link cycle that flips their toggle
	assign tel_evt = tt_s ^ tt_seen_reg;
	assign wr_evt  = wt_s ^ wt_seen_reg;
	assign all_on  = ~en_s & hold_s;
	assign src     = cmd_reg[rtoi_pkg::TEL_SRC_MSB:rtoi_pkg::TEL_SRC_LSB];

	always_comb begin
		lk_next      = lk_reg;
		mask_next    = mask_reg;
		reply_next   = reply_reg;
		ack_next     = ack_reg;
		if (wr_evt) begin
			unique case (lk_reg)
			rtoi_pkg::LK_NONE: begin
				if (cmd_reg == rtoi_pkg::OUTPUT_SWITCH_MASK_OFS &&
				    data_reg == rtoi_pkg::UNLOCK_DATA) begin
					lk_next = rtoi_pkg::LK_FIRST; // RULE21
				end
			end
			rtoi_pkg::LK_FIRST: begin
				if (cmd_reg == rtoi_pkg::CMD_UNLOCK2 &&
				    data_reg == rtoi_pkg::UNLOCK_DATA) begin
					lk_next = rtoi_pkg::LK_OPEN; // RULE21
				end else if (cmd_reg != rtoi_pkg::OUTPUT_SWITCH_MASK_OFS ||
				             data_reg != rtoi_pkg::UNLOCK_DATA) begin
					lk_next = rtoi_pkg::LK_NONE;
				end
			end
			rtoi_pkg::LK_OPEN: begin
				if (cmd_reg == rtoi_pkg::OUTPUT_SWITCH_MASK_OFS) begin
					mask_next = data_reg[rtoi_pkg::SW_USED_W-1:0]; // RULE17
				end
			end
			default: lk_next = rtoi_pkg::LK_NONE;
			endcase
		end
		if (tel_evt) begin
			ack_next = ~ack_reg;
			if (cmd_reg[rtoi_pkg::TEL_FLAG_BIT] &&
			    cmd_reg[3:0] == rtoi_pkg::TEL_LOW_ZERO) begin // RULE5
				unique case (src) // RULE7
				rtoi_pkg::SRC_TEMP: reply_next = readings_i.temp;
				rtoi_pkg::SRC_MAIN: reply_next = readings_i.main_rail;
				rtoi_pkg::SRC_LOW:  reply_next = readings_i.low_rail;
				rtoi_pkg::SRC_MID:  reply_next = readings_i.mid_rail;
				rtoi_pkg::SRC_PAUX: reply_next =
					readings_i.positive_aux_rail;
				rtoi_pkg::SRC_NAUX: reply_next =
					readings_i.negative_aux_rail;
				default:            reply_next = rtoi_pkg::REPLY_BAD;
				endcase
			end else begin
				reply_next = rtoi_pkg::REPLY_BAD;
			end
		end
		// RULE18
		on_next.main_rail = all_on & ~mask_reg[rtoi_pkg::SW_MAIN_BIT]; // RULE11
		on_next.low_rail  = all_on & ~mask_reg[rtoi_pkg::SW_LOW_BIT]; // RULE12
		on_next.mid_rail  = all_on & ~mask_reg[rtoi_pkg::SW_GROUP_BIT] &
		                    ~mask_reg[rtoi_pkg::SW_MID_BIT]; // RULE13 RULE14
		on_next.positive_aux_rail = all_on &
			~mask_reg[rtoi_pkg::SW_GROUP_BIT] &
			~mask_reg[rtoi_pkg::SW_PAUX_BIT]; // RULE13 RULE15
		on_next.negative_aux_rail = all_on &
			~mask_reg[rtoi_pkg::SW_GROUP_BIT] &
			~mask_reg[rtoi_pkg::SW_NAUX_BIT]; // RULE13 RULE16
		on_next.aux_low_rail = ~en_s; // RULE18
		fault_n_next = ~(|fault_s); // RULE19
		good_n_next  = ~(&good_s); // RULE20
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tt_seen_reg <= 1'b0;
			wt_seen_reg <= 1'b0;
			lk_reg      <= rtoi_pkg::LK_NONE;
			mask_reg    <= rtoi_pkg::MASK_RESET; // RULE8
			reply_reg   <= rtoi_pkg::REPLY_BAD;
			ack_reg     <= 1'b0;
			on_reg      <= '0;
			fault_n_reg <= 1'b1;
			good_n_reg  <= 1'b1;
		end else begin
			tt_seen_reg <= tt_s;
			wt_seen_reg <= wt_s;
			lk_reg      <= lk_next;
			mask_reg    <= mask_next;
			reply_reg   <= reply_next;
			ack_reg     <= ack_next;
			on_reg      <= on_next;
			fault_n_reg <= fault_n_next;
			good_n_reg  <= good_n_next;
		end
	end

	assign rail_on        = on_reg;
	assign fault_n        = fault_n_reg;
	assign outputs_good_n = good_n_reg;

	// Link domain checks
	property p_tel_addr;
		@(posedge link_clk) disable iff (lrst)
		(st_reg == rtoi_pkg::L_AACK && tel_reg) |->
			sr_reg[7:1] == tel_addr;
	endproperty
	a_tel_addr: assert property (p_tel_addr) // RULE1
		else $error("telemetry acknowledged a foreign address");

	property p_ctl_addr;
		@(posedge link_clk) disable iff (lrst)
		(st_reg == rtoi_pkg::L_AACK && !tel_reg) |->
			sr_reg[7:1] == ctl_addr;
	endproperty
	a_ctl_addr: assert property (p_ctl_addr) // RULE3
		else $error("controller acknowledged a foreign address");

	property p_one_byte;
		@(posedge link_clk) disable iff (lrst)
		(st_reg == rtoi_pkg::L_RACK && scl_fall) |=>
			(st_reg == rtoi_pkg::L_IDLE && !oe_reg);
	endproperty
	a_one_byte: assert property (p_one_byte) // RULE6
		else $error("telemetry reply ran past one byte");

	// System domain checks
	sequence s_tel_req;
		tel_evt;
	endsequence
	sequence s_tel_ans;
		ack_reg != $past(ack_reg);
	endsequence
	property p_tel_ans;
		@(posedge clk) disable iff (sys_rst)
		s_tel_req |=> s_tel_ans;
	endproperty
	a_tel_ans: assert property (p_tel_ans) // RULE22
		else $error("telemetry command not answered");

	property p_temp_sel;
		@(posedge clk) disable iff (sys_rst)
		(tel_evt && cmd_reg == 8'h80) |=> reply_reg == $past(readings_i.temp);
	endproperty
	a_temp_sel: assert property (p_temp_sel) // RULE5
		else $error("temperature command returned another source");

	property p_power_up;
		@(posedge clk) sys_rst |=> mask_reg == rtoi_pkg::MASK_RESET;
	endproperty
	a_power_up: assert property (p_power_up) // RULE8
		else $error("outputs not all on after reset");

	property p_locked;
		@(posedge clk) disable iff (sys_rst)
		(lk_reg != rtoi_pkg::LK_OPEN) |=> $stable(mask_reg);
	endproperty
	a_locked: assert property (p_locked) // RULE21
		else $error("switch mask changed while locked");

	property p_stay_open;
		@(posedge clk) disable iff (sys_rst)
		(lk_reg == rtoi_pkg::LK_OPEN) |=>
			(lk_reg == rtoi_pkg::LK_OPEN) [*2];
	endproperty
	a_stay_open: assert property (p_stay_open) // RULE21
		else $error("controller relocked");

	property p_group_off;
		@(posedge clk) disable iff (sys_rst)
		mask_reg[rtoi_pkg::SW_GROUP_BIT] |=> !on_reg.mid_rail &&
			!on_reg.positive_aux_rail && !on_reg.negative_aux_rail;
	endproperty
	a_group_off: assert property (p_group_off) // RULE13
		else $error("group bit did not switch outputs off");

	property p_main_off;
		@(posedge clk) disable iff (sys_rst)
		(all_on && !mask_reg[rtoi_pkg::SW_MAIN_BIT]) ##1
		mask_reg[rtoi_pkg::SW_MAIN_BIT] |=> !on_reg.main_rail;
	endproperty
	a_main_off: assert property (p_main_off) // RULE11
		else $error("main output stayed on");

	property p_enable_off;
		@(posedge clk) disable iff (sys_rst)
		en_s |=> on_reg == '0;
	endproperty
	a_enable_off: assert property (p_enable_off) // RULE18
		else $error("outputs on while enable high");

	property p_fault;
		@(posedge clk) disable iff (sys_rst)
		(|fault_s) |=> !fault_n_reg;
	endproperty
	a_fault: assert property (p_fault) // RULE19
		else $error("fault not indicated");

	property p_good;
		@(posedge clk) disable iff (sys_rst)
		(&good_s) |=> !good_n_reg;
	endproperty
	a_good: assert property (p_good) // RULE20
		else $error("outputs-good not indicated");
endmodule : rtoi_top

// File: verif/rtoi_i2c_mst.sv
// Behavioural serial bus master facing the management slaves
`timescale 1ns/1ps
module rtoi_i2c_mst #(
	parameter int Q_NS = 1250
) (
	output logic      scl,     // Serial clock, idle high
	output logic      sda_low, // Pulls the data line low
	input  wire logic sda_in   // Resolved data line
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Four quarters per bit: 5 us, so the clock never exceeds 200 kHz
	task automatic put_bit(input logic b);
		sda_low = !b;
		#(Q_NS) scl = 1'b1;
		#(2*Q_NS) scl = 1'b0;
		#(Q_NS);
	endtask : put_bit

	task automatic get_bit(output logic b);
		sda_low = 1'b0;
		#(Q_NS) scl = 1'b1;
		#(Q_NS) b = sda_in;
		#(Q_NS) scl = 1'b0;
		#(Q_NS);
	endtask : get_bit

	// Also serves as repeated start; clock stays still between frames
	task automatic start;
		sda_low = 1'b0;
		#(Q_NS) scl = 1'b1;
		#(Q_NS) sda_low = 1'b1;
		#(Q_NS) scl = 1'b0;
		#(Q_NS);
	endtask : start

	task automatic stop;
		sda_low = 1'b1;
		#(Q_NS) scl = 1'b1;
		#(Q_NS) sda_low = 1'b0;
		#(2*Q_NS);
	endtask : stop

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i]);
		end
		get_bit(b);
		ack = !b;
	endtask : wr_byte

	task automatic rd_byte(output logic [7:0] d, input logic nack);
		for (int i = 7; i >= 0; i--) begin
			get_bit(d[i]);
		end
		put_bit(nack);
	endtask : rd_byte
endmodule : rtoi_i2c_mst

// File: verif/rtoi_top_tb.sv
// Self-checking bench for the telemetry and on/off management block
`timescale 1ns/1ps
module rtoi_top_tb;
	logic                     clk;
	logic                     sys_rst;
	logic                     link_clk;
	logic                     scl;
	logic                     m_low;
	logic                     sda_o;
	logic                     sda_oe;
	logic                     sda_line;
	logic [1:0]               slot;
	logic                     enable_n;
	logic                     holdoff_n;
	rtoi_pkg::rtoi_readings_t rd;
	rtoi_pkg::rtoi_rails_t    flt;
	rtoi_pkg::rtoi_rails_t    good;
	rtoi_pkg::rtoi_rails_t    rail_on;
	logic                     fault_n;
	logic                     outputs_good_n;
	int                       err_total;
	int                       cmp_count;
	logic [7:0]               masks [4] = '{8'h09, 8'h12, 8'h24, 8'hE0};
	logic [2:0]               srcs [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

	// Pull-up on the data line: high unless someone pulls it low
	assign sda_line = !(m_low | (sda_oe & !sda_o));

	rtoi_top i_dut (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.link_clk       (link_clk),
		.scl_i          (scl),
		.sda_i          (sda_line),
		.sda_o          (sda_o),
		.sda_oe         (sda_oe),
		.slot_addr_hi   (slot[1]),
		.slot_addr_lo   (slot[0]),
		.enable_n       (enable_n),
		.holdoff_n      (holdoff_n),
		.readings_i     (rd),
		.rail_fault_i   (flt),
		.rail_good_i    (good),
		.rail_on        (rail_on),
		.fault_n        (fault_n),
		.outputs_good_n (outputs_good_n)
	);

	rtoi_i2c_mst i_mst (
		.scl     (scl),
		.sda_low (m_low),
		.sda_in  (sda_line)
	);

	initial clk = 1'b0;
	always #12.5 clk = !clk;
	initial begin
		link_clk = 1'b0;
		#7;
		forever #32 link_clk = !link_clk;
	end

	task automatic results;
		if (err_total == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	function automatic logic [5:0] exp_rails(input logic en_n,
		input logic ho_n, input logic [7:0] m);
		logic on;
		on = !en_n & ho_n;
		return {on & !m[0], on & !m[1], on & !m[2] & !m[3],
			on & !m[2] & !m[4], on & !m[2] & !m[5], !en_n};
	endfunction : exp_rails

	function automatic logic [7:0] exp_read(input logic [2:0] s);
		case (s)
			3'h0: return rd.temp;
			3'h4: return rd.main_rail;
			3'h1: return rd.low_rail;
			3'h5: return rd.mid_rail;
			3'h2: return rd.positive_aux_rail;
			default: return rd.negative_aux_rail;
		endcase
	endfunction : exp_read

	task automatic ctl_write(input logic [7:0] cmd, input logic [7:0] dat);
		logic a;
		i_mst.start();
		i_mst.wr_byte({rtoi_pkg::CTL_ADDR_HI, slot, 1'b0}, a);
		chk_val({7'h00, a}, 8'h01);
		i_mst.wr_byte(cmd, a);
		i_mst.wr_byte(dat, a);
		i_mst.stop();
		repeat (20) @(negedge clk);
	endtask : ctl_write

	task automatic tel_read(input logic [2:0] s);
		logic       a;
		logic [7:0] d;
		i_mst.start();
		i_mst.wr_byte({rtoi_pkg::TEL_ADDR_HI, slot, 1'b0}, a);
		chk_val({7'h00, a}, 8'h01);
		i_mst.wr_byte({1'b1, s, 4'h0}, a);
		i_mst.start();
		i_mst.wr_byte({rtoi_pkg::TEL_ADDR_HI, slot, 1'b1}, a);
		i_mst.rd_byte(d, 1'b1);
		i_mst.stop();
		chk_val(d, exp_read(s));
	endtask : tel_read

	initial begin
		#(104000 * 25);
		err_total++;
		results();
	end

	initial begin
		logic a;
		err_total = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		slot = 2'b00;
		enable_n = 1'b0;
		holdoff_n = 1'b1;
		rd = {8'h3C, 8'hA5, 8'h5A, 8'h96, 8'h69, 8'hC3};
		flt = '0;
		good = '0;
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		repeat (40) @(negedge clk);
		chk_val({2'b00, rail_on}, 8'h3F);
		for (int i = 3; i >= 0; i--) begin
			{enable_n, holdoff_n} = i[1:0];
			repeat (5) @(negedge clk);
			chk_val({2'b00, rail_on}, {2'b00, exp_rails(i[1], i[0], 8'h00)});
		end
		holdoff_n = 1'b1;
		flt = 6'h04;
		good = 6'h3F;
		repeat (5) @(negedge clk);
		chk_val({6'h00, fault_n, outputs_good_n}, 8'h00);
		flt = 6'h00;
		good = 6'h3E;
		repeat (5) @(negedge clk);
		chk_val({6'h00, fault_n, outputs_good_n}, 8'h03);
		slot = 2'b10;
		i_mst.start();
		i_mst.wr_byte({rtoi_pkg::TEL_ADDR_HI, 2'b01, 1'b0}, a);
		i_mst.stop();
		chk_val({7'h00, a}, 8'h00);
		ctl_write(8'h02, 8'h3F);
		chk_val({2'b00, rail_on}, 8'h3F);
		ctl_write(8'h02, 8'h00);
		ctl_write(8'h06, 8'h00);
		chk_val({2'b00, rail_on}, 8'h3F);
		foreach (masks[i]) begin
			ctl_write(8'h02, masks[i]);
			chk_val({2'b00, rail_on}, {2'b00, exp_rails(1'b0, 1'b1, masks[i])});
		end
		foreach (srcs[i]) begin
			slot = i[1:0];
			tel_read(srcs[i]);
		end
		results();
	end
endmodule : rtoi_top_tb
